// ---- dmo_decoded_m_output_port.sv ----
// Purpose: decoded M output port with shared alternate functions
// Assumes: inputs synchronous to sys_clk; table loaded through a write port
// Notes: alternate functions OR onto the decoded levels; in closed loop the spindle bit drops its decoded level
`timescale 1ns/10ps
module dmo_decoded_m_output_port #(
    parameter int NUM_FUNCS = dmo_pkg::NUM_FUNCS,
    parameter int MFUNC_W = dmo_pkg::MFUNC_W,
    parameter int TOOL_W = dmo_pkg::TOOL_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    // table write port
    input wire logic tableWrite,
    input wire logic [MFUNC_W-1:0] tableIndex,
    input wire logic [14:0] tableActivate,
    input wire logic [14:0] tableDeactivate,
    // M function execution
    input wire logic mExecute,
    input wire logic [MFUNC_W-1:0] mCode,
    // configuration flags
    input wire logic fourthAxisPresentFlag,
    input wire logic thirdAxisPresentFlag,
    input wire logic thirdAxisAsRotaryFlag,
    input wire logic rapidMoveIndicateFlag,
    input wire logic turretDirectionOutputFlag,
    // machine state
    input wire logic fourthAxisEnable,
    input wire logic thirdAxisEnable,
    input wire logic spindleClosedLoopMode,
    input wire logic spindleInPosition,
    input wire logic rapidPositioningMove,
    input wire logic jogModeSelected,
    // turret
    input wire logic [TOOL_W-1:0] turretSize,
    input wire logic [TOOL_W-1:0] currentTool,
    input wire logic turretMoveStart,
    input wire logic [TOOL_W-1:0] requestedTool,
    input wire logic turretRotating,
    // outputs
    output logic [14:0] decodedOutputs,
    output logic jogIndicator,
    output logic turretPositive
);
    initial begin
        if (NUM_FUNCS < 1 || NUM_FUNCS > (1 << MFUNC_W)) begin
            $error("table size does not fit the code width");
        end
        if (TOOL_W < 2) begin
            $error("tool field too narrow");
        end
    end

    // ----------------------------------------
    // M function table
    // ----------------------------------------
    logic [14:0] actTable [NUM_FUNCS];
    logic [14:0] deactTable [NUM_FUNCS];
    logic [14:0] decoded_q;
    logic [14:0] decoded_d;
    wire tableHit = int'(mCode) < NUM_FUNCS;
    wire [14:0] selAct = tableHit ? actTable[mCode] : dmo_pkg::MASK_RESET;
    wire [14:0] selDeact = tableHit ? deactTable[mCode] : dmo_pkg::MASK_RESET;

    // activate wins where both masks name the same output
    // bitwise per position, so mask bit n touches only decoded bit n (output n+1)
    assign decoded_d = mExecute
        ? ((decoded_q & ~selDeact) | selAct)
        : decoded_q;

    always_ff @(posedge sys_clk) begin
        if (tableWrite && int'(tableIndex) < NUM_FUNCS) begin
            actTable[tableIndex] <= tableActivate;
            deactTable[tableIndex] <= tableDeactivate;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            decoded_q <= dmo_pkg::OUT_RESET;
        end else begin
            decoded_q <= decoded_d;
        end
    end

    // ----------------------------------------
    // turret direction
    // ----------------------------------------
    // forward distance modulo turret size; ties go positive
    logic [TOOL_W:0] fwdRaw;
    logic [TOOL_W:0] fwdDist;
    logic [TOOL_W:0] sizeExt;
    logic dir_q;
    assign sizeExt = {1'b0, turretSize};
    assign fwdRaw = {1'b0, requestedTool} - {1'b0, currentTool};
    assign fwdDist = (requestedTool >= currentTool) ? fwdRaw
                                                   : fwdRaw + sizeExt;
    wire pickPositive = ({fwdDist, 1'b0} <= {1'b0, sizeExt});

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dir_q <= 1'b0;
        end else if (turretMoveStart) begin
            dir_q <= pickPositive;
        end
    end

    // ----------------------------------------
    // alternate functions
    // ----------------------------------------
    logic [14:0] altOut;
    wire spindleLock = spindleClosedLoopMode & spindleInPosition;
    wire cAxisEnable = thirdAxisPresentFlag & thirdAxisAsRotaryFlag
                       & thirdAxisEnable;
    wire dirLevel = turretRotating & dir_q;
    always_comb begin
        altOut = 15'h0000;
        altOut[dmo_pkg::IDX_FOURTH_EN] =
            fourthAxisPresentFlag & fourthAxisEnable;
        altOut[dmo_pkg::IDX_THIRD_EN] =
            thirdAxisPresentFlag & thirdAxisEnable;
        altOut[dmo_pkg::IDX_TURRET_DIR] =
            turretDirectionOutputFlag & dirLevel;
        altOut[dmo_pkg::IDX_RAPID] =
            rapidMoveIndicateFlag & rapidPositioningMove;
        altOut[dmo_pkg::IDX_SPINDLE] = spindleLock | cAxisEnable;
    end

    // in closed loop the lock overrides the table bit so it can go low
    wire [14:0] tableView = spindleClosedLoopMode
        ? (decoded_d & ~(15'h0001 << dmo_pkg::IDX_SPINDLE))
        : decoded_d;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            decodedOutputs <= dmo_pkg::OUT_RESET;
            jogIndicator <= 1'b0;
            turretPositive <= 1'b0;
        end else begin
            decodedOutputs <= tableView | altOut;
            jogIndicator <= jogModeSelected;
            turretPositive <= dir_q;
        end
    end
endmodule

// ---- dmo_pkg.sv ----
// Purpose: constants shared by the decoded output port
// Assumes: outputs numbered 1..15, bit n-1 of a vector is output n
// Notes: no register map; configuration arrives as plain ports
package dmo_pkg;
    localparam int NUM_OUTPUTS = 15;
    localparam int NUM_FUNCS = 100;
    localparam int MFUNC_W = 7;
    localparam int TOOL_W = 5;
    localparam int MAX_TOOLS = 32;
    localparam int DEF_TOOLS = 12;
    // zero-based bit indices of the shared outputs
    localparam int IDX_FOURTH_EN = 10;
    localparam int IDX_THIRD_EN = 11;
    localparam int IDX_TURRET_DIR = 12;
    localparam int IDX_RAPID = 13;
    localparam int IDX_SPINDLE = 14;
    localparam logic [14:0] OUT_RESET = 15'h0000;
    localparam logic [14:0] MASK_RESET = 15'h0000;
endpackage

// ---- dmo_port_checker.sv ----
// Purpose: port checks; Assumes: alt inputs lag one edge; Notes: bound
`timescale 1ns/10ps
module dmo_port_checker (
    input wire logic sys_clk, rst, mExecute, jogModeSelected,
    input wire logic fourthAxisPresentFlag, fourthAxisEnable,
    input wire logic thirdAxisPresentFlag, thirdAxisEnable,
    input wire logic thirdAxisAsRotaryFlag, rapidMoveIndicateFlag,
    input wire logic rapidPositioningMove, spindleClosedLoopMode,
    input wire logic spindleInPosition, jogIndicator,
    input wire logic [14:0] decodedOutputs
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic cAxis = thirdAxisPresentFlag && thirdAxisAsRotaryFlag
        && thirdAxisEnable;
    jog_follow_a: assert property (jogModeSelected |=> jogIndicator)
        else $error("jog indicator low");
    hold_bits_a: assert property (!mExecute |=> $stable(decodedOutputs[9:0]))
        else $error("outputs moved without execute");
    fourth_en_a: assert property (fourthAxisPresentFlag && fourthAxisEnable
        |=> decodedOutputs[10]) else $error("fourth enable low");
    third_en_a: assert property (thirdAxisPresentFlag && thirdAxisEnable
        |=> decodedOutputs[11]) else $error("third enable low");
    rapid_ind_a: assert property (rapidMoveIndicateFlag && rapidPositioningMove
        |=> decodedOutputs[13]) else $error("rapid output low");
    c_axis_a: assert property (cAxis |=> decodedOutputs[14])
        else $error("c axis enable low");
    lock_set_a: assert property (spindleClosedLoopMode && spindleInPosition
        |=> decodedOutputs[14]) else $error("lock low in position");
    lock_free_a: assert property (spindleClosedLoopMode && !spindleInPosition
        && !cAxis |=> !decodedOutputs[14]) else $error("lock high while moving");
endmodule
bind dmo_decoded_m_output_port dmo_port_checker chk_u (.*);

// ---- dmo_relay_bank.sv ----
// Purpose: relay bank; Assumes: one-cycle pickup; Notes: no feedback
`timescale 1ns/10ps
module dmo_relay_bank (
    input wire logic sys_clk,
    input wire logic [14:0] coilDrive,
    output logic [14:0] contact
);
    always_ff @(posedge sys_clk) contact <= coilDrive;
endmodule

// ---- test_dmo_decoded_m_output_port.sv ----
// Purpose: port bench; Assumes: inputs at falling edge; Notes: queue check
`timescale 1ns/10ps
module test_dmo_decoded_m_output_port;
logic sys_clk='0, rst='1, tableWrite='0, mExecute='0, turretMoveStart='0;
logic fourthAxisPresentFlag='0, thirdAxisPresentFlag='0, fourthAxisEnable='0;
logic thirdAxisAsRotaryFlag='0, rapidMoveIndicateFlag='0, thirdAxisEnable='0;
logic turretDirectionOutputFlag='0, turretRotating='0, jogModeSelected='0;
logic rapidPositioningMove='0, spindleClosedLoopMode='0, spindleInPosition='0;
logic [6:0] tableIndex='0, mCode='0;
logic [4:0] turretSize=5'h0c, currentTool=5'h02, requestedTool=5'h04;
logic [14:0] tableActivate='0, tableDeactivate='0, st='0, ta[128], td[128];
logic [14:0] decodedOutputs;
logic jogIndicator, turretPositive;
logic [15:0] q[$];
int bad_count=0, compares=0, cyc=0, seed=32'h4fa61603, i;
dmo_decoded_m_output_port dut_u (.*);
dmo_relay_bank rly_u (.sys_clk(sys_clk), .coilDrive(decodedOutputs), .contact());
always #5 sys_clk = ~sys_clk;
task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
        bad_count++;
        $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
endtask
task automatic close_out(input int hung);
    bad_count += hung;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
task automatic wr(input logic [6:0] x, input logic [14:0] a, d);
    @(negedge sys_clk) tableWrite = 1'h1;
    {tableIndex, tableActivate, tableDeactivate} = {x, a, d};
    {ta[x], td[x]} = {a, d};
    @(negedge sys_clk) tableWrite = 1'h0;
endtask
task automatic ex(input logic [6:0] c, input logic [14:0] alt);
    @(negedge sys_clk) {mExecute, mCode} = {1'h1, c};
    if (c < 7'h64) st = (st & ~td[c]) | ta[c];
    q.push_back({jogModeSelected, st | alt});
endtask
always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 1500) close_out(1);
    if (mExecute) begin
        @(negedge sys_clk);
        check({jogIndicator, decodedOutputs}, q.pop_front());
    end
end
initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'h0;
    wr(7'h29, 15'h4924, 15'h1249);
    wr(7'h78, 15'h7fff, 15'h0000);
    wr(7'h08, 15'h0000, 15'h7c00);
    for (i = 0; i < 8; i++) wr(i[6:0], 15'($random(seed)), 15'($random(seed)));
    ex(7'h29, '0);
    ex(7'h78, '0);
    for (i = 0; i < 16; i++) ex(7'($unsigned($random(seed)) % 8), '0);
    ex(7'h08, '0);
    @(negedge sys_clk) mExecute = 1'h0;
    {fourthAxisPresentFlag, fourthAxisEnable, thirdAxisPresentFlag} = 3'h7;
    {thirdAxisEnable, thirdAxisAsRotaryFlag, rapidMoveIndicateFlag} = 3'h7;
    {rapidPositioningMove, turretDirectionOutputFlag, jogModeSelected} = 3'h7;
    {turretMoveStart, turretRotating} = 2'h3;
    @(negedge sys_clk) turretMoveStart = 1'h0;
    ex(7'h78, 15'h7c00);
    @(negedge sys_clk) mExecute = 1'h0;
    {thirdAxisAsRotaryFlag, spindleClosedLoopMode} = 2'h1;
    ex(7'h78, 15'h3c00);
    @(negedge sys_clk) {mExecute, spindleInPosition, jogModeSelected} = 3'h2;
    ex(7'h78, 15'h7c00);
    @(negedge sys_clk) mExecute = 1'h0;
    check({15'h0000, turretPositive}, 16'h0001);
    requestedTool = 5'h0a;
    turretMoveStart = 1'h1;
    @(negedge sys_clk) turretMoveStart = 1'h0;
    @(negedge sys_clk) check({15'h0000, turretPositive}, 16'h0000);
    check({15'h0000, decodedOutputs[12]}, {15'h0000, st[12]});
    @(negedge sys_clk) close_out(0);
end
endmodule
